/* File: pkg/ext_int_pkg.sv */
// shared constants and types for the external interrupt detection block
package ext_int_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam int PIN_COUNT = 6;

	// ****************************************
	// register offsets (word index on the plain port)
	// ****************************************
	localparam logic [ADDR_W-1:0] OFS_SENSE_CONTROL = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_REQUEST_STATUS = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_EVENT_CLEAR = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_EVENT_ENABLE = 3'h4;

	// ****************************************
	// field positions
	// ****************************************
	localparam int POS_NMI_PIN_LEVEL = 15;
	localparam int POS_NMI_EDGE_SELECT = 8;
	localparam int POS_NMI_EVENT = 8;
	// request pin order 0,1,2,3,6,7 -> register bits 7,6,5,4,1,0
	localparam int PIN_BIT_POS [PIN_COUNT] = '{7, 6, 5, 4, 1, 0};

	// ****************************************
	// reset values
	// ****************************************
	localparam logic RST_NMI_EDGE_SELECT = 1'h0;
	localparam logic [PIN_COUNT-1:0] RST_SENSE_SEL = 6'h00;
	localparam logic [PIN_COUNT-1:0] RST_REQUEST_FLAG = 6'h00;
	localparam logic [DATA_W-1:0] RST_EVENT = 16'h0000;
	localparam logic [DATA_W-1:0] RST_READ_DATA = 16'h0000;
	// idle level of a request pin and the nmi pin before sampling
	localparam logic PIN_IDLE = 1'h1;

	// ****************************************
	// encodings
	// ****************************************
	localparam logic SENSE_LOW_LEVEL = 1'h0;
	localparam logic SENSE_FALLING_EDGE = 1'h1;
	localparam logic NMI_EDGE_FALLING = 1'h0;
	localparam logic NMI_EDGE_RISING = 1'h1;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	// pin-ordered vector placed at its register bit positions
	function automatic logic [DATA_W-1:0] pins_to_reg(input logic [PIN_COUNT-1:0] v);
		logic [DATA_W-1:0] r;
		r = '0;
		for (int i = 0; i < PIN_COUNT; i++) begin
			r[PIN_BIT_POS[i]] = v[i];
		end
		return r;
	endfunction

	// register bit positions gathered into pin order
	function automatic logic [PIN_COUNT-1:0] reg_to_pins(input logic [DATA_W-1:0] r);
		logic [PIN_COUNT-1:0] v;
		v = '0;
		for (int i = 0; i < PIN_COUNT; i++) begin
			v[i] = r[PIN_BIT_POS[i]];
		end
		return v;
	endfunction

endpackage

/* File: src/ext_interrupt_detect.sv */
// external interrupt detection: nmi edge, request pin sensing, registers and event interrupt
//
// Added by the designer: the address map and the address-and-strobe port.
module ext_interrupt_detect
	import ext_int_pkg::*;
(
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic NMI_PIN,
	input wire logic [PIN_COUNT-1:0] EXT_INT_N,
	input wire logic [PIN_COUNT-1:0] EXT_INT_ACK,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [DATA_W-1:0] RDATA,
	output logic NMI_REQ,
	output logic [PIN_COUNT-1:0] EXT_INT_REQ,
	output logic IRQ
);

	// ****************************************
	// bus request
	// ****************************************
	reg_req_s req;

	assign req.addr = ADDR;
	assign req.wdata = WDATA;
	assign req.wr = WR;
	assign req.rd = RD;

	wire hit_ctrl = (req.addr == OFS_SENSE_CONTROL);
	wire hit_stat = (req.addr == OFS_REQUEST_STATUS);
	wire hit_evst = (req.addr == OFS_EVENT_STATUS);
	wire hit_evcl = (req.addr == OFS_EVENT_CLEAR);
	wire hit_even = (req.addr == OFS_EVENT_ENABLE);

	wire wr_ctrl = req.wr & hit_ctrl;
	wire wr_stat = req.wr & hit_stat;
	wire rd_stat = req.rd & hit_stat;
	wire wr_evcl = req.wr & hit_evcl;
	wire wr_even = req.wr & hit_even;

	// ****************************************
	// pin synchronisation
	// ****************************************
	logic nmi_sync;
	logic [PIN_COUNT-1:0] ext_sync;

	pin_sync #(
		.WIDTH(1)
	) u_nmi_sync (
		.clk(CLOCK),
		.srst(SRST),
		.async_in(NMI_PIN),
		.sync_out(nmi_sync)
	);

	pin_sync #(
		.WIDTH(PIN_COUNT)
	) u_ext_sync (
		.clk(CLOCK),
		.srst(SRST),
		.async_in(EXT_INT_N),
		.sync_out(ext_sync)
	);

	// ****************************************
	// control register
	// ****************************************
	// only the power-on reset touches these; no standby input exists
	logic nmi_edge_select_q;
	logic [PIN_COUNT-1:0] sense_sel_q;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			nmi_edge_select_q <= RST_NMI_EDGE_SELECT;
			sense_sel_q <= RST_SENSE_SEL;
		end else if (wr_ctrl) begin
			nmi_edge_select_q <= req.wdata[POS_NMI_EDGE_SELECT];
			sense_sel_q <= reg_to_pins(req.wdata);
		end
	end

	// ****************************************
	// nmi edge detection
	// ****************************************
	logic nmi_prev_q;
	logic nmi_req_q;
	logic nmi_rise;
	logic nmi_fall;
	logic nmi_hit;

	assign nmi_rise = ~nmi_prev_q & nmi_sync;
	assign nmi_fall = nmi_prev_q & ~nmi_sync;
	assign nmi_hit = (nmi_edge_select_q == NMI_EDGE_RISING) ? nmi_rise : nmi_fall;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			nmi_prev_q <= PIN_IDLE;
			nmi_req_q <= 1'b0;
		end else begin
			nmi_prev_q <= nmi_sync;
			nmi_req_q <= nmi_hit;
		end
	end

	assign NMI_REQ = nmi_req_q;

	// ****************************************
	// request flags, one cell per pin
	// ****************************************
	logic [PIN_COUNT-1:0] flag;
	logic [PIN_COUNT-1:0] flag_set;
	logic [PIN_COUNT-1:0] wr_bits;

	assign wr_bits = reg_to_pins(req.wdata);

	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_cell
		request_flag_cell u_cell (
			.clk(CLOCK),
			.srst(SRST),
			.pin_n(ext_sync[i]),
			.sense_sel(sense_sel_q[i]),
			.status_read(rd_stat),
			.status_write(wr_stat),
			.write_bit(wr_bits[i]),
			.ack(EXT_INT_ACK[i]),
			.flag(flag[i]),
			.set_event(flag_set[i])
		);
	end

	// flags already come from cell flip-flops
	assign EXT_INT_REQ = flag;

	// ****************************************
	// event status, clear and enable
	// ****************************************
	logic [DATA_W-1:0] ev_status_q;
	logic [DATA_W-1:0] ev_enable_q;
	logic [DATA_W-1:0] ev_in;
	logic [DATA_W-1:0] ev_clr;
	logic [DATA_W-1:0] ev_mask;
	logic irq_q;

	// only implemented bits may hold anything
	assign ev_mask = pins_to_reg({PIN_COUNT{1'b1}}) | (16'h0001 << POS_NMI_EVENT);
	assign ev_in = pins_to_reg(flag_set) | ({15'h0000, nmi_hit} << POS_NMI_EVENT);
	assign ev_clr = wr_evcl ? req.wdata : RST_EVENT;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			ev_status_q <= RST_EVENT;
			ev_enable_q <= RST_EVENT;
			irq_q <= 1'b0;
		end else begin
			// a new event beats a clear in the same cycle
			ev_status_q <= ((ev_status_q & ~ev_clr) | ev_in) & ev_mask;
			if (wr_even) begin
				ev_enable_q <= req.wdata & ev_mask;
			end
			irq_q <= |(((ev_status_q & ~ev_clr) | ev_in) & ev_enable_q);
		end
	end

	assign IRQ = irq_q;

	// ****************************************
	// read data
	// ****************************************
	logic [DATA_W-1:0] ctrl_view;
	logic [DATA_W-1:0] stat_view;
	logic [DATA_W-1:0] rd_mux;
	logic [DATA_W-1:0] rdata_q;

	// reserved bits stay zero because nothing else is ORed in
	assign ctrl_view = pins_to_reg(sense_sel_q)
		| ({15'h0000, nmi_edge_select_q} << POS_NMI_EDGE_SELECT)
		| ({15'h0000, nmi_sync} << POS_NMI_PIN_LEVEL);
	assign stat_view = pins_to_reg(flag);

	assign rd_mux = hit_ctrl ? ctrl_view :
		hit_stat ? stat_view :
		hit_evst ? ev_status_q :
		hit_even ? ev_enable_q :
		RST_READ_DATA;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			rdata_q <= RST_READ_DATA;
		end else if (req.rd) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= RST_READ_DATA;
		end
	end

	assign RDATA = rdata_q;

endmodule // ext_interrupt_detect

/* File: src/pin_sync.sv */
// two-stage synchroniser for asynchronous pin levels
module pin_sync
	import ext_int_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ****************************************
	// stages
	// ****************************************
	// first stage is read only by the second
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= {WIDTH{PIN_IDLE}};
			sync_q <= {WIDTH{PIN_IDLE}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule // pin_sync

/* File: src/request_flag_cell.sv */
// one request pin: level or falling-edge sensing and its request flag
module request_flag_cell
	import ext_int_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic pin_n,
	input wire logic sense_sel,
	input wire logic status_read,
	input wire logic status_write,
	input wire logic write_bit,
	input wire logic ack,
	output logic flag,
	output logic set_event
);

	// ****************************************
	// state
	// ****************************************
	logic prev_q;
	logic flag_q;
	logic flag_d;
	logic armed_q;
	logic armed_d;
	logic fall;
	logic edge_mode;
	logic sw_clear;

	assign edge_mode = (sense_sel == SENSE_FALLING_EDGE);
	// one registered previous level, so one edge sets the flag only once
	assign fall = prev_q & ~pin_n;
	// a zero write only counts after a read that saw one
	assign sw_clear = status_write & ~write_bit & armed_q;
	// the new edge wins over any clear in the same cycle
	assign flag_d = !edge_mode ? ~pin_n :
		(fall ? 1'b1 : ((sw_clear | ack) ? 1'b0 : flag_q));
	assign armed_d = status_read ? (flag_q & edge_mode) : (status_write ? 1'b0 : armed_q);

	always_ff @(posedge clk) begin
		if (srst) begin
			prev_q <= PIN_IDLE;
			flag_q <= 1'b0;
			armed_q <= 1'b0;
			set_event <= 1'b0;
		end else begin
			prev_q <= pin_n;
			flag_q <= flag_d;
			armed_q <= armed_d;
			set_event <= flag_d & ~flag_q;
		end
	end

	assign flag = flag_q;

endmodule // request_flag_cell

/* File: tb/ext_interrupt_detect_asserts.sv */
// port-level assertions for the external interrupt detection block
module ext_interrupt_detect_asserts
	import ext_int_pkg::*;
(
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic NMI_PIN,
	input wire logic [PIN_COUNT-1:0] EXT_INT_N,
	input wire logic [PIN_COUNT-1:0] EXT_INT_ACK,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [DATA_W-1:0] RDATA,
	input wire logic NMI_REQ,
	input wire logic [PIN_COUNT-1:0] EXT_INT_REQ,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	// shadow of the control bits, which the ports do not show
	logic [PIN_COUNT-1:0] sense_q;
	logic sel_q;
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			sense_q <= 6'h00;
			sel_q <= 1'h0;
		end else if (WR && ADDR == 3'h0) begin
			sense_q <= {WDATA[0], WDATA[1], WDATA[4], WDATA[5], WDATA[6], WDATA[7]};
			sel_q <= WDATA[8];
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SRST);
	sequence nmi_fall_s;
		!sel_q && $fell(NMI_PIN);
	endsequence
	sequence nmi_rise_s;
		sel_q && $rose(NMI_PIN);
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	ctrl_rsvd_a: assert property (
		$past(RD) && $past(ADDR) == 3'h0 |-> (RDATA & 16'h7e0c) == 16'h0000) else $error("control reserved bit set");
	nmi_level_a: assert property (
		$past(RD) && $past(ADDR) == 3'h0 && $past(NMI_PIN, 2) == $past(NMI_PIN) && $past(NMI_PIN, 3) == $past(NMI_PIN)
		&& $past(NMI_PIN, 4) == $past(NMI_PIN) |-> RDATA[15] == $past(NMI_PIN)) else $error("nmi level wrong");
	nmi_edge_a: assert property (
		nmi_fall_s or nmi_rise_s |-> ##3 NMI_REQ) else $error("nmi edge missed");
	level_flag_a: assert property (
		sense_q == 6'h00 && $past(sense_q, 3) == 6'h00 && $stable(EXT_INT_N) && $past(EXT_INT_N, 2) == EXT_INT_N
		&& $past(EXT_INT_N, 3) == EXT_INT_N |-> EXT_INT_REQ == ~EXT_INT_N) else $error("level flag wrong");
	edge_set_a: assert property (
		sense_q[0] && $fell(EXT_INT_N[0]) |-> ##3 EXT_INT_REQ[0]) else $error("edge flag not set");
	edge_hold_a: assert property (
		sense_q[0] && EXT_INT_REQ[0] && !EXT_INT_ACK[0] && !WR |=> EXT_INT_REQ[0]) else $error("edge flag lost");
	ack_clear_a: assert property (
		sense_q[0] && EXT_INT_ACK[0] && EXT_INT_N[0] && $past(EXT_INT_N[0]) && $past(EXT_INT_N[0], 2)
		|=> !EXT_INT_REQ[0]) else $error("flag not cleared by ack");
	reset_clear_a: assert property (
		$fell(SRST) |-> EXT_INT_REQ == 6'h00 && !IRQ && !NMI_REQ) else $error("requests survive reset");
endmodule // ext_interrupt_detect_asserts

bind ext_interrupt_detect ext_interrupt_detect_asserts chk_u (.CLOCK(CLOCK), .SRST(SRST), .NMI_PIN(NMI_PIN),
	.EXT_INT_N(EXT_INT_N), .EXT_INT_ACK(EXT_INT_ACK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .NMI_REQ(NMI_REQ), .EXT_INT_REQ(EXT_INT_REQ), .IRQ(IRQ));

/* File: tb/ext_pins.sv */
// behavioural external devices on the request pins and the nmi pin
module ext_pins
	import ext_int_pkg::*;
(
	input wire logic clk,
	output logic [PIN_COUNT-1:0] int_n,
	output logic nmi
);
	timeunit 1ns;
	timeprecision 1ps;
	// pins rest high as if pulled up, so no request is seen by accident
	initial begin
		int_n = 6'h3f;
		nmi = 1'h1;
	end
	task automatic drive(input logic [PIN_COUNT-1:0] v, input logic n);
		@(posedge clk);
		int_n <= v;
		nmi <= n;
	endtask
endmodule // ext_pins

/* File: tb/tb.sv */
// self-checking bench for the external interrupt detection block
module tb
	import ext_int_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock;
	logic srst = 1'h1;
	logic nmi_pin;
	logic [PIN_COUNT-1:0] int_n;
	logic [PIN_COUNT-1:0] ack = 6'h00;
	logic [ADDR_W-1:0] addr = 3'h0;
	logic [DATA_W-1:0] wdata = 16'h0000;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [DATA_W-1:0] rdata;
	logic nmi_req;
	logic [PIN_COUNT-1:0] req;
	logic irq;
	logic [DATA_W-1:0] nmi_pulses = 16'h0000;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;

	ext_pins pins_u (.clk(clock), .int_n(int_n), .nmi(nmi_pin));
	ext_interrupt_detect dut_u (.CLOCK(clock), .SRST(srst), .NMI_PIN(nmi_pin), .EXT_INT_N(int_n),
		.EXT_INT_ACK(ack), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.NMI_REQ(nmi_req), .EXT_INT_REQ(req), .IRQ(irq));

	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end
	// the whole run needs some 130 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		// nmi request is a one-cycle pulse, so the bench keeps a tally
		if (nmi_req === 1'h1) begin
			nmi_pulses <= nmi_pulses + 16'h0001;
		end
		if (cycles == 3000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus_w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clock);
		wr <= 1'h0;
	endtask
	task automatic bus_r(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clock);
		addr <= a;
		rd <= 1'h1;
		@(posedge clock);
		rd <= 1'h0;
		#1;
		check(rdata, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		idle(12);
		srst <= 1'h0;
		bus_r(3'h0, 16'h8000);
		bus_r(3'h1, 16'h0000);
		bus_r(3'h5, 16'h0000);
		bus_w(3'h0, 16'h01f3);
		bus_r(3'h0, 16'h81f3);
		$display("test control done");
		pins_u.drive(6'h3f, 1'h0);
		idle(4);
		bus_r(3'h0, 16'h01f3);
		bus_r(3'h2, 16'h0000);
		pins_u.drive(6'h3f, 1'h1);
		idle(4);
		bus_r(3'h2, 16'h0100);
		check(nmi_pulses, 16'h0001);
		pins_u.drive(6'h00, 1'h1);
		idle(4);
		pins_u.drive(6'h3f, 1'h1);
		idle(4);
		check({10'h000, req}, 16'h003f);
		bus_r(3'h1, 16'h00f3);
		// writing ones or an unarmed zero must leave the flags
		bus_w(3'h1, 16'h00f3);
		bus_w(3'h1, 16'h0000);
		bus_r(3'h1, 16'h00f3);
		bus_w(3'h1, 16'h00f0);
		bus_r(3'h1, 16'h00f0);
		@(posedge clock);
		ack <= 6'h01;
		@(posedge clock);
		ack <= 6'h00;
		idle(2);
		bus_r(3'h1, 16'h0070);
		$display("test edge done");
		bus_r(3'h2, 16'h01f3);
		bus_w(3'h4, 16'h0080);
		idle(2);
		check({15'h0000, irq}, 16'h0001);
		bus_w(3'h3, 16'h0080);
		idle(2);
		check({15'h0000, irq}, 16'h0000);
		bus_r(3'h2, 16'h0173);
		pins_u.drive(6'h3e, 1'h1);
		idle(5);
		check({15'h0000, irq}, 16'h0001);
		bus_r(3'h4, 16'h0080);
		$display("test interrupt done");
		bus_w(3'h0, 16'h0000);
		idle(4);
		bus_r(3'h1, 16'h0080);
		pins_u.drive(6'h3f, 1'h1);
		idle(4);
		bus_r(3'h1, 16'h0000);
		$display("test level done");
		bus_w(3'h0, 16'h01f3);
		pins_u.drive(6'h3d, 1'h1);
		idle(4);
		pins_u.drive(6'h3f, 1'h1);
		idle(4);
		check({10'h000, req}, 16'h0002);
		srst <= 1'h1;
		idle(3);
		srst <= 1'h0;
		bus_r(3'h0, 16'h8000);
		bus_r(3'h1, 16'h0000);
		pins_u.drive(6'h3f, 1'h0);
		idle(4);
		bus_r(3'h2, 16'h0100);
		check(nmi_pulses, 16'h0002);
		pins_u.drive(6'h3f, 1'h1);
		$display("test reset done");
		complete_run();
	end
endmodule // tb
